/* File: hdl/pfs_pin_mux.v */
// Purpose: Pad function selection for port E bits 4-6, port F bits 0-3, port G and port J bits 0-1.
// Assumes: APB3 slave on pclk; pad inputs arrive asynchronously.
// Notes: Every pad output and peripheral input is registered.
`timescale 1ns/1ps
`include "pfs_consts.vh"
module pfs_pin_mux (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PFS_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [`PFS_NPAD-1:0] gpio_do,
    input wire [`PFS_NPAD-1:0] gpio_oe,
    input wire [`PFS_NPAD-1:0] pad_di,
    output wire [`PFS_NPAD-1:0] gpio_di,
    output wire [`PFS_NPAD-1:0] pad_do,
    output wire [`PFS_NPAD-1:0] pad_oe,
    output wire [`PFS_NPAD-1:0] pad_lcd_en,
    output wire [`PFS_NPAD-1:0] pad_supply_en,
    input wire [7:4] periodic_timer_output,
    input wire comparator_two_output,
    input wire serial_clock_do,
    input wire serial_clock_oe,
    input wire serial_data_in_or_i2c_data_do,
    input wire serial_data_in_or_i2c_data_oe,
    input wire serial_data_out,
    input wire serial_data_out_oe,
    input wire serial_chip_select_n_do,
    input wire serial_chip_select_n_oe,
    output wire [7:4] pf_periodic_timer_clock_input,
    output wire [5:4] pj_periodic_timer_clock_input,
    output wire serial_clock_di,
    output wire serial_data_in_or_i2c_data_di,
    output wire serial_chip_select_n_di
);

    // ****************************************************************
    // Pad function tables, codes 11,10,01,00 from left to right
    // ****************************************************************
    localparam [`PFS_MAP_W-1:0] MAP_E4 = {`PFS_FN_SUPPLY, `PFS_FN_GPIO,
        `PFS_FN_GPIO, `PFS_FN_GPIO};
    localparam [`PFS_MAP_W-1:0] MAP_E5 = {`PFS_FN_LCD, `PFS_FN_ALTB,
        `PFS_FN_RSVD, `PFS_FN_GPIO};
    localparam [`PFS_MAP_W-1:0] MAP_E6 = {`PFS_FN_LCD, `PFS_FN_RSVD,
        `PFS_FN_GPIO, `PFS_FN_GPIO};
    localparam [`PFS_MAP_W-1:0] MAP_F0 = {`PFS_FN_LCD, `PFS_FN_ALTB,
        `PFS_FN_ALTA, `PFS_FN_GPIO};
    localparam [`PFS_MAP_W-1:0] MAP_F1 = {`PFS_FN_LCD, `PFS_FN_ALTB,
        `PFS_FN_ALTA, `PFS_FN_GPIO};
    localparam [`PFS_MAP_W-1:0] MAP_F2 = {`PFS_FN_LCD, `PFS_FN_ALTB,
        `PFS_FN_GPIO, `PFS_FN_GPIO};
    localparam [`PFS_MAP_W-1:0] MAP_F3 = {`PFS_FN_LCD, `PFS_FN_ALTB,
        `PFS_FN_GPIO, `PFS_FN_GPIO};
    localparam [`PFS_MAP_W-1:0] MAP_GL = {`PFS_FN_LCD, `PFS_FN_GPIO,
        `PFS_FN_GPIO, `PFS_FN_GPIO};
    localparam [`PFS_MAP_W-1:0] MAP_GH = {`PFS_FN_LCD, `PFS_FN_LCD,
        `PFS_FN_GPIO, `PFS_FN_GPIO};
    localparam [`PFS_MAP_W-1:0] MAP_J0 = {`PFS_FN_LCD, `PFS_FN_ALTB,
        `PFS_FN_GPIO, `PFS_FN_GPIO};
    localparam [`PFS_MAP_W-1:0] MAP_J1 = {`PFS_FN_LCD, `PFS_FN_ALTB,
        `PFS_FN_GPIO, `PFS_FN_GPIO};
    localparam [`PFS_NPAD*`PFS_MAP_W-1:0] MAPS = {MAP_J1, MAP_J0,
        MAP_GH, MAP_GH, MAP_GH, MAP_GH, MAP_GL, MAP_GL, MAP_GL, MAP_GL,
        MAP_F3, MAP_F2, MAP_F1, MAP_F0, MAP_E6, MAP_E5, MAP_E4};

    // ****************************************************************
    // Register file and APB slave
    // ****************************************************************
    reg [`PFS_E_HIGH_W-1:0] port_e_high_function_select_reg;
    reg [7:0] port_f_low_function_select_reg;
    reg [7:0] port_f_high_function_select_reg;
    reg [7:0] port_g_low_function_select_reg;
    reg [7:0] port_g_high_function_select_reg;
    reg [`PFS_J_W-1:0] port_j_function_select_reg;
    reg pready_reg;
    reg pslverr_reg;
    reg [31:0] prdata_reg;
    reg [31:0] prdata_next;
    wire [`PFS_NREG-1:0] hit;
    wire wr_en;

    function [`PFS_NREG-1:0] reg_hit;
        input [`PFS_ADDR_W-1:0] a;
        begin
            case (a)
                `PFS_OFS_E_HIGH: reg_hit = 6'h01;
                `PFS_OFS_F_LOW: reg_hit = 6'h02;
                `PFS_OFS_F_HIGH: reg_hit = 6'h04;
                `PFS_OFS_G_LOW: reg_hit = 6'h08;
                `PFS_OFS_G_HIGH: reg_hit = 6'h10;
                `PFS_OFS_J: reg_hit = 6'h20;
                default: reg_hit = 6'h00;
            endcase
        end
    endfunction

    assign hit = reg_hit(paddr);
    // A write lands only on the edge at which the master sees pready.
    assign wr_en = psel & penable & pwrite & pready_reg;

    always @* begin
        prdata_next = 32'h0000_0000;
        case (hit)
            6'h01: prdata_next[`PFS_E_HIGH_W-1:0] =
                port_e_high_function_select_reg;
            6'h02: prdata_next[7:0] = port_f_low_function_select_reg;
            6'h04: prdata_next[7:0] = port_f_high_function_select_reg;
            6'h08: prdata_next[7:0] = port_g_low_function_select_reg;
            6'h10: prdata_next[7:0] = port_g_high_function_select_reg;
            6'h20: prdata_next[`PFS_J_W-1:0] =
                port_j_function_select_reg;
            default: prdata_next = 32'h0000_0000;
        endcase
    end

    // One wait state keeps pready, prdata and pslverr straight from flops.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (psel && penable && !pready_reg) begin
            pready_reg <= 1'b1;
            pslverr_reg <= (hit == 6'h00);
            prdata_reg <= pwrite ? 32'h0000_0000 : prdata_next;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_e_high_function_select_reg <= 6'h00;
            port_f_low_function_select_reg <= `PFS_RESET_VAL;
            port_f_high_function_select_reg <= `PFS_RESET_VAL;
            port_g_low_function_select_reg <= `PFS_RESET_VAL;
            port_g_high_function_select_reg <= `PFS_RESET_VAL;
            port_j_function_select_reg <= 4'h0;
        end else if (wr_en) begin
            if (hit[0]) begin
                port_e_high_function_select_reg <=
                    pwdata[`PFS_E_HIGH_W-1:0];
            end
            if (hit[1]) begin
                port_f_low_function_select_reg <= pwdata[7:0];
            end
            if (hit[2]) begin
                port_f_high_function_select_reg <= pwdata[7:0];
            end
            if (hit[3]) begin
                port_g_low_function_select_reg <= pwdata[7:0];
            end
            if (hit[4]) begin
                port_g_high_function_select_reg <= pwdata[7:0];
            end
            if (hit[5]) begin
                port_j_function_select_reg <= pwdata[`PFS_J_W-1:0];
            end
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    // ****************************************************************
    // Pad input synchronisers
    // ****************************************************************
    reg [`PFS_NPAD-1:0] pad_sync1_reg;
    reg [`PFS_NPAD-1:0] pad_sync2_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_sync1_reg <= 17'h0_0000;
            pad_sync2_reg <= 17'h0_0000;
        end else begin
            pad_sync1_reg <= pad_di;
            pad_sync2_reg <= pad_sync1_reg;
        end
    end

    assign gpio_di = pad_sync2_reg;

    // ****************************************************************
    // Alternate output sources per pad
    // ****************************************************************
    wire [2*`PFS_NPAD-1:0] codes;
    reg [`PFS_NPAD-1:0] alta_do;
    reg [`PFS_NPAD-1:0] alta_oe;
    reg [`PFS_NPAD-1:0] altb_do;
    reg [`PFS_NPAD-1:0] altb_oe;

    assign codes = {port_j_function_select_reg,
        port_g_high_function_select_reg, port_g_low_function_select_reg,
        port_f_low_function_select_reg, port_e_high_function_select_reg};

    always @* begin
        alta_do = 17'h0_0000;
        alta_oe = 17'h0_0000;
        altb_do = 17'h0_0000;
        altb_oe = 17'h0_0000;
        altb_do[`PFS_PAD_E5] = comparator_two_output;
        altb_oe[`PFS_PAD_E5] = 1'b1;
        altb_do[`PFS_PAD_F3] = serial_clock_do;
        altb_oe[`PFS_PAD_F3] = serial_clock_oe;
        altb_do[`PFS_PAD_F2] = serial_data_in_or_i2c_data_do;
        altb_oe[`PFS_PAD_F2] = serial_data_in_or_i2c_data_oe;
        alta_do[`PFS_PAD_F1] = periodic_timer_output[6];
        alta_oe[`PFS_PAD_F1] = 1'b1;
        altb_do[`PFS_PAD_F1] = serial_data_out;
        altb_oe[`PFS_PAD_F1] = serial_data_out_oe;
        alta_do[`PFS_PAD_F0] = periodic_timer_output[7];
        alta_oe[`PFS_PAD_F0] = 1'b1;
        altb_do[`PFS_PAD_F0] = serial_chip_select_n_do;
        altb_oe[`PFS_PAD_F0] = serial_chip_select_n_oe;
        altb_do[`PFS_PAD_J1] = periodic_timer_output[5];
        altb_oe[`PFS_PAD_J1] = 1'b1;
        altb_do[`PFS_PAD_J0] = periodic_timer_output[4];
        altb_oe[`PFS_PAD_J0] = 1'b1;
    end

    // ****************************************************************
    // Per-pad decode and registered pad drive
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < `PFS_NPAD; i = i + 1) begin : g_pad
            wire [`PFS_NCLS-1:0] cls;
            reg do_reg;
            reg oe_reg;
            reg lcd_reg;
            reg supply_reg;

            pfs_field_decode #(
                .MAP(MAPS[i*`PFS_MAP_W +: `PFS_MAP_W])
            ) u_dec (
                .code(codes[2*i +: 2]),
                .cls(cls)
            );

            // Reserved codes release the pad so a bad write cannot fight.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    do_reg <= 1'b0;
                    oe_reg <= 1'b0;
                    lcd_reg <= 1'b0;
                    supply_reg <= 1'b0;
                end else begin
                    do_reg <= (cls[`PFS_BIT_GPIO] & gpio_do[i]) |
                        (cls[`PFS_BIT_ALTA] & alta_do[i]) |
                        (cls[`PFS_BIT_ALTB] & altb_do[i]);
                    oe_reg <= (cls[`PFS_BIT_GPIO] & gpio_oe[i]) |
                        (cls[`PFS_BIT_ALTA] & alta_oe[i]) |
                        (cls[`PFS_BIT_ALTB] & altb_oe[i]);
                    lcd_reg <= cls[`PFS_BIT_LCD];
                    supply_reg <= cls[`PFS_BIT_SUPPLY];
                end
            end

            assign pad_do[i] = do_reg;
            assign pad_oe[i] = oe_reg;
            assign pad_lcd_en[i] = lcd_reg;
            assign pad_supply_en[i] = supply_reg;
        end
    endgenerate

    // ****************************************************************
    // Peripheral inputs taken from pads
    // ****************************************************************
    reg [7:4] pf_periodic_timer_clock_input_reg;
    reg [5:4] pj_periodic_timer_clock_input_reg;
    reg sck_di_reg;
    reg sdi_di_reg;
    reg scs_n_di_reg;

    // Both candidate timer clock pins are offered; the input source
    // selector elsewhere picks one, so unselected pads read as zero.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_periodic_timer_clock_input_reg <= 4'h0;
            pj_periodic_timer_clock_input_reg <= 2'h0;
            sck_di_reg <= 1'b0;
            sdi_di_reg <= 1'b0;
            scs_n_di_reg <= 1'b1;
        end else begin
            pf_periodic_timer_clock_input_reg[4] <= pad_sync2_reg[`PFS_PAD_F0] &
                (codes[2*`PFS_PAD_F0 +: 2] == `PFS_CODE_0);
            pf_periodic_timer_clock_input_reg[5] <= pad_sync2_reg[`PFS_PAD_F1] &
                (codes[2*`PFS_PAD_F1 +: 2] == `PFS_CODE_0);
            pf_periodic_timer_clock_input_reg[6] <= pad_sync2_reg[`PFS_PAD_F2] &
                ~codes[2*`PFS_PAD_F2+1];
            pf_periodic_timer_clock_input_reg[7] <= pad_sync2_reg[`PFS_PAD_F3] &
                ~codes[2*`PFS_PAD_F3+1];
            pj_periodic_timer_clock_input_reg[4] <= pad_sync2_reg[`PFS_PAD_J1] &
                ~codes[2*`PFS_PAD_J1+1];
            pj_periodic_timer_clock_input_reg[5] <= pad_sync2_reg[`PFS_PAD_J0] &
                ~codes[2*`PFS_PAD_J0+1];
            sck_di_reg <= pad_sync2_reg[`PFS_PAD_F3] &
                (codes[2*`PFS_PAD_F3 +: 2] == `PFS_CODE_2);
            sdi_di_reg <= pad_sync2_reg[`PFS_PAD_F2] &
                (codes[2*`PFS_PAD_F2 +: 2] == `PFS_CODE_2);
            // Chip select idles high so a deselected pad never enables.
            scs_n_di_reg <= ~(codes[2*`PFS_PAD_F0 +: 2] == `PFS_CODE_2) |
                pad_sync2_reg[`PFS_PAD_F0];
        end
    end

    assign pf_periodic_timer_clock_input = pf_periodic_timer_clock_input_reg;
    assign pj_periodic_timer_clock_input = pj_periodic_timer_clock_input_reg;
    assign serial_clock_di = sck_di_reg;
    assign serial_data_in_or_i2c_data_di = sdi_di_reg;
    assign serial_chip_select_n_di = scs_n_di_reg;

endmodule // pfs_pin_mux

/* File: inc/pfs_consts.vh */
// Purpose: Constants for the port E/F/G/J pad function select block.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes: Pad numbering is used by the pin mux; function class codes are shared by both modules.
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define PFS_ADDR_W 8
`define PFS_OFS_E_HIGH 8'h00
`define PFS_OFS_F_LOW 8'h04
`define PFS_OFS_F_HIGH 8'h08
`define PFS_OFS_G_LOW 8'h0C
`define PFS_OFS_G_HIGH 8'h10
`define PFS_OFS_J 8'h14
`define PFS_RESET_VAL 8'h00
`define PFS_E_HIGH_W 6
`define PFS_J_W 4
`define PFS_NREG 6

// ****************************************************************
// Pad numbering
// ****************************************************************
`define PFS_NPAD 17
`define PFS_PAD_E4 0
`define PFS_PAD_E5 1
`define PFS_PAD_E6 2
`define PFS_PAD_F0 3
`define PFS_PAD_F1 4
`define PFS_PAD_F2 5
`define PFS_PAD_F3 6
`define PFS_PAD_J0 15
`define PFS_PAD_J1 16

// ****************************************************************
// Field codes and function classes
// ****************************************************************
`define PFS_CODE_0 2'h0
`define PFS_CODE_2 2'h2
`define PFS_CLS_W 3
`define PFS_MAP_W 12
`define PFS_NCLS 6
`define PFS_FN_GPIO 3'h0
`define PFS_FN_RSVD 3'h1
`define PFS_FN_ALTA 3'h2
`define PFS_FN_ALTB 3'h3
`define PFS_FN_LCD 3'h4
`define PFS_FN_SUPPLY 3'h5
`define PFS_BIT_GPIO 0
`define PFS_BIT_RSVD 1
`define PFS_BIT_ALTA 2
`define PFS_BIT_ALTB 3
`define PFS_BIT_LCD 4
`define PFS_BIT_SUPPLY 5

`endif

/* File: hdl/pfs_field_decode.v */
// Purpose: Decode one 2-bit pad select field into a one-hot class.
// Assumes: MAP packs the class of codes 3,2,1,0 from high to low.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "pfs_consts.vh"
module pfs_field_decode #(
    parameter [`PFS_MAP_W-1:0] MAP = {`PFS_MAP_W{1'b0}}
) (
    input wire [1:0] code,
    output wire [`PFS_NCLS-1:0] cls
);

    // ****************************************************************
    // Class lookup
    // ****************************************************************
    function [`PFS_NCLS-1:0] class_onehot;
        input [`PFS_CLS_W-1:0] c;
        begin
            case (c)
                `PFS_FN_GPIO: class_onehot = 6'h01;
                `PFS_FN_RSVD: class_onehot = 6'h02;
                `PFS_FN_ALTA: class_onehot = 6'h04;
                `PFS_FN_ALTB: class_onehot = 6'h08;
                `PFS_FN_LCD: class_onehot = 6'h10;
                `PFS_FN_SUPPLY: class_onehot = 6'h20;
                default: class_onehot = 6'h02;
            endcase
        end
    endfunction

    wire [`PFS_CLS_W-1:0] picked;

    assign picked = MAP[code*`PFS_CLS_W +: `PFS_CLS_W];
    assign cls = class_onehot(picked);

endmodule // pfs_field_decode

/* File: verification/pfs_pin_mux_properties.sv */
// Purpose: Bus timing and pad class properties of the pad select block.
// Assumes: One clock domain; presetn is asynchronous and active low.
// Notes: Sees only the top ports; bound at the foot of this file.
`timescale 1ns/1ps
`include "pfs_consts.vh"
module pfs_pin_mux_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PFS_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`PFS_NPAD-1:0] pad_oe,
    input wire logic [`PFS_NPAD-1:0] pad_lcd_en,
    input wire logic [`PFS_NPAD-1:0] pad_supply_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    chk_ready_wait: assert property (s_setup ##1 s_access |=> pready)
        else $error("ready late after the first access edge");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without an access phase");
    chk_rdata_quiet: assert property ((!pready || pwrite) |->
        prdata == 32'h0000_0000)
        else $error("read data outside a read answer");
    chk_j_high_zero: assert property ((pready && !pwrite &&
        paddr == `PFS_OFS_J) |-> prdata[7:4] == 4'h0)
        else $error("port J upper bits read nonzero");
    chk_err_bad_addr: assert property (pready |-> pslverr ==
        ((paddr > `PFS_OFS_J) || (paddr[1:0] != 2'b00)))
        else $error("error flag does not match the address");
    chk_supply_e4_only: assert property (pad_supply_en[16:1] == 16'h0)
        else $error("supply input on a pad other than E4");
    chk_supply_no_drive: assert property (pad_supply_en[0] |->
        !pad_oe[0] && !pad_lcd_en[0])
        else $error("supply pad driven or handed to the display");
    chk_lcd_no_drive: assert property ((pad_lcd_en & pad_oe) == 17'h0)
        else $error("display pad also driven as output");
    chk_e4_no_lcd: assert property (!pad_lcd_en[0])
        else $error("E4 handed to the display");
endmodule // pfs_pin_mux_properties
bind pfs_pin_mux pfs_pin_mux_properties pfs_pin_mux_properties_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_oe(pad_oe), .pad_lcd_en(pad_lcd_en),
    .pad_supply_en(pad_supply_en)
);

/* File: verification/pfs_pad_model.sv */
// Purpose: Package pads and peripheral drivers around the select block.
// Assumes: A pad the block releases is held by an outside source.
// Notes: Outside levels and peripheral drives are loaded by the bench.
`timescale 1ns/1ps
`include "pfs_consts.vh"
module pfs_pad_model (
    input wire logic [`PFS_NPAD-1:0] pad_do,
    input wire logic [`PFS_NPAD-1:0] pad_oe,
    output logic [`PFS_NPAD-1:0] pad_di,
    output logic [7:4] tmr_out,
    output logic cmp_out,
    output logic sck_do,
    output logic sck_oe,
    output logic sdi_do,
    output logic sdi_oe,
    output logic sdo_do,
    output logic sdo_oe,
    output logic cs_n_do,
    output logic cs_oe
);
    logic [`PFS_NPAD-1:0] ext_reg = 17'h0;
    logic [12:0] drv_reg = 13'h0;
    assign {tmr_out, cmp_out, sck_do, sck_oe, sdi_do, sdi_oe, sdo_do, sdo_oe,
            cs_n_do, cs_oe} = drv_reg;
    // A driven pad reads its own level; a released one shows the outside
    // source, so stale block data can never be mistaken for a pad level.
    assign pad_di = (pad_oe & pad_do) | (~pad_oe & ext_reg);
    task automatic load(input [16:0] ext, input [12:0] drv);
        ext_reg <= ext;
        drv_reg <= drv;
    endtask
endmodule // pfs_pad_model

/* File: verification/pfs_pin_mux_tb.sv */
// Purpose: Self-checking bench for the pad function select block.
// Assumes: The bus slave answers after one wait state.
// Notes: Pad expectations follow from the select codes written.
`timescale 1ns/1ps
`include "pfs_consts.vh"
module pfs_pin_mux_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, cmp_out, sck_do, sck_oe, sdi_do, sdi_oe;
    logic sdo_do, sdo_oe, cs_n_do, cs_oe, sck_di, sdi_di, cs_n_di;
    logic [16:0] gpio_do = 17'h0, gpio_oe = 17'h0, pad_di, gpio_di;
    logic [16:0] pad_do, pad_oe, pad_lcd_en, pad_supply_en;
    logic [7:4] tmr_out, pf_tck;
    logic [5:4] pj_tck;
    int failures = 0, cmp_count = 0, cycles = 0;
    always #5 pclk = ~pclk;
    pfs_pin_mux pfs_pin_mux_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gpio_do(gpio_do),
        .gpio_oe(gpio_oe), .pad_di(pad_di), .gpio_di(gpio_di),
        .pad_do(pad_do), .pad_oe(pad_oe), .pad_lcd_en(pad_lcd_en),
        .pad_supply_en(pad_supply_en), .periodic_timer_output(tmr_out),
        .comparator_two_output(cmp_out), .serial_clock_do(sck_do),
        .serial_clock_oe(sck_oe), .serial_data_in_or_i2c_data_do(sdi_do),
        .serial_data_in_or_i2c_data_oe(sdi_oe), .serial_data_out(sdo_do),
        .serial_data_out_oe(sdo_oe), .serial_chip_select_n_do(cs_n_do),
        .serial_chip_select_n_oe(cs_oe),
        .pf_periodic_timer_clock_input(pf_tck),
        .pj_periodic_timer_clock_input(pj_tck), .serial_clock_di(sck_di),
        .serial_data_in_or_i2c_data_di(sdi_di),
        .serial_chip_select_n_di(cs_n_di)
    );
    pfs_pad_model pfs_pad_model_i (
        .pad_do(pad_do), .pad_oe(pad_oe), .pad_di(pad_di),
        .tmr_out(tmr_out), .cmp_out(cmp_out), .sck_do(sck_do),
        .sck_oe(sck_oe), .sdi_do(sdi_do), .sdi_oe(sdi_oe), .sdo_do(sdo_do),
        .sdo_oe(sdo_oe), .cs_n_do(cs_n_do), .cs_oe(cs_oe)
    );
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            print_verdict;
        end
    end
    task automatic check(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    // The bus is kept selected when another transfer follows at once, so
    // no signal is assigned twice at the edge between two transfers.
    task automatic xfer(input [7:0] a, input w, input [31:0] d, input more,
                        output [31:0] r, output e);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            failures++;
        r = prdata;
        e = pslverr;
        if (!more) begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d, input more);
        logic [31:0] r;
        logic e;
        xfer(a, 1'b1, d, more, r, e);
    endtask
    task automatic rd(input [7:0] a, input [31:0] exp, input eerr,
                      input more);
        logic [31:0] r;
        logic e;
        xfer(a, 1'b0, 32'h0, more, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, eerr});
    endtask
    task automatic cfg(input [7:0] e, input [7:0] f, input [7:0] gl,
                       input [7:0] gh, input [7:0] j);
        wr(`PFS_OFS_E_HIGH, {24'h0, e}, 1'b1);
        wr(`PFS_OFS_F_LOW, {24'h0, f}, 1'b1);
        wr(`PFS_OFS_G_LOW, {24'h0, gl}, 1'b1);
        wr(`PFS_OFS_G_HIGH, {24'h0, gh}, 1'b1);
        wr(`PFS_OFS_J, {24'h0, j}, 1'b0);
    endtask
    task automatic pads(input [16:0] oe, input [16:0] dv, input [16:0] lcd,
                        input [8:0] pin);
        // Pad flop, two sync flops and the peripheral input flop follow
        // the write edge; outputs are read before each edge updates them.
        repeat (5) @(posedge pclk);
        check({15'h0, pad_oe}, {15'h0, oe});
        check({15'h0, pad_do & pad_oe}, {15'h0, dv});
        check({15'h0, pad_lcd_en}, {15'h0, lcd});
        check({23'h0, pf_tck, pj_tck, sck_di, sdi_di, cs_n_di}, {23'h0, pin});
    endtask
    task automatic t_reset;
        gpio_oe <= 17'h0_00F0;
        gpio_do <= 17'h0_0050;
        for (int i = 0; i < 6; i++)
            rd(8'(4 * i), 32'h0, 1'b0, i < 5);
        pads(17'h0_00F0, 17'h0_0050, 17'h0_0000, 9'h179);
        check({15'h0, gpio_di}, 32'h0001_FF5F);
        $display("test reset done");
    endtask
    task automatic t_regs;
        logic [7:0] ex [6] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
        for (int i = 0; i < 6; i++)
            wr(8'(4 * i), 32'hFFFF_FFFF, 1'b1);
        wr(8'h18, 32'hFFFF_FFFF, 1'b1);
        for (int i = 0; i < 6; i++)
            rd(8'(4 * i), {24'h0, ex[i]}, 1'b0, 1'b1);
        rd(8'h18, 32'h0, 1'b1, 1'b0);
        pads(17'h0_0000, 17'h0_0000, 17'h1_FFFE, 9'h001);
        check({15'h0, pad_supply_en}, 32'h1);
        $display("test registers done");
    endtask
    task automatic t_alt;
        gpio_oe <= 17'h0_0000;
        gpio_do <= 17'h0_0000;
        pfs_pad_model_i.load(17'h1_FFFF, 13'h03ED);
        cfg(8'h0A, 8'hAA, 8'hAA, 8'hAA, 8'h0A);
        pads(17'h1_805A, 17'h0_8052, 17'h0_7800, 9'h006);
        $display("test alternate functions done");
    endtask
    task automatic t_one;
        gpio_oe <= 17'h0_0005;
        gpio_do <= 17'h0_0001;
        pfs_pad_model_i.load(17'h0_FFFF, 13'h0800);
        cfg(8'h11, 8'h55, 8'h55, 8'h55, 8'h05);
        pads(17'h0_001D, 17'h0_0011, 17'h0_0000, 9'h191);
        check({15'h0, gpio_di}, 32'h0000_FFF3);
        $display("test timer functions done");
    endtask
    task automatic t_rerun;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++)
            rd(8'(4 * i), 32'h0, 1'b0, i < 5);
        pads(17'h0_0005, 17'h0_0001, 17'h0_0000, 9'h1F1);
        $display("test second reset done");
    endtask
    initial begin
        @(posedge pclk);
        pfs_pad_model_i.load(17'h1_FFFF, 13'h0000);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_regs;
        t_alt;
        t_one;
        t_rerun;
        print_verdict;
    end
endmodule // pfs_pin_mux_tb
